// ### hdl/latc_top.sv
// Option-driven axle, traction help, level and lamp control
`timescale 1ns/10ps
module latc_top import latc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DEB_CYCLES = DEB_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Configuration store
  input wire logic [OPT_W-1:0] opt_i,
  // Driver switch pins
  input wire logic axle_sw_i,
  input wire logic axle_up_btn_i,
  input wire logic axle_dn_btn_i,
  input wire logic th_btn_i,
  input wire logic th_enable_sw_i,
  input wire logic nl_sw_i,
  input wire logic nl_up_btn_i,
  input wire logic nl_dn_btn_i,
  // Remote unit and fault logic
  input wire logic rcu_raise_i,
  input wire logic rcu_lower_i,
  input wire logic rcu_stop_i,
  input wire logic minor_fault_i,
  input wire logic axle_overload_i,
  // Measurements
  input wire logic [SPW-1:0] speed_i,
  input wire logic [PW-1:0] bellows_press_i,
  input wire logic [PW-1:0] press_raw_i,
  // Parameter set
  input wire logic [PW-1:0] press_limit_i,
  input wire logic [PW-1:0] press_max_i,
  input wire logic [PW-1:0] press_min_i,
  input wire logic [SPW-1:0] spd_limit_i,
  input wire logic [SPW-1:0] spd_up_i,
  input wire logic [SPW-1:0] spd_dn_i,
  input wire logic [12:0] th_time_s_i,
  input wire logic th_time_en_i,
  // Status and actuators
  output logic th_active_o,
  output logic th_blocked_o,
  output logic axle_down_o,
  output logic auto_on_o,
  output logic raise_valve_o,
  output logic level2_o,
  output logic lamp_o,
  output logic level_abort_o,
  output logic axle_reverse_o,
  output logic [DW-1:0] press_diag_o
);
  // ==========================================================
  // Time base, input conditioning, option capture
  logic tick;
  logic [DB_W-1:0] db;
  logic [DB_W-1:0] db_prev;
  logic db_valid;
  logic db_seen;
  logic [OPT_W-1:0] opt;
  logic [DB_W-1:0] rise_v;
  logic [DB_W-1:0] fall_v;

  latc_tick #(.DIV(TICK_CYCLES)) u_tick (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .tick_o(tick)
  );

  latc_debounce #(.W(DB_W), .CNT(DEB_CYCLES)) u_deb (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .raw_i({nl_dn_btn_i, nl_up_btn_i, nl_sw_i, th_enable_sw_i,
            th_btn_i, axle_dn_btn_i, axle_up_btn_i, axle_sw_i}),
    .db_o(db),
    .valid_o(db_valid)
  );

  // Options load while reset is held and freeze afterwards
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      opt <= opt_i; // R22
      db_prev <= '0;
      db_seen <= 1'b0;
    end else begin
      db_prev <= db;
      db_seen <= db_valid;
    end
  end

  // No edges until the debouncer has settled, so power-up is not a change
  assign rise_v = db & ~db_prev & {DB_W{db_seen}}; // R23
  assign fall_v = ~db & db_prev & {DB_W{db_seen}};

  // ==========================================================
  // Lifting/trailing axle
  logic two_pos;
  logic raise_cmd;
  logic lower_cmd;
  logic over_lim;
  logic at_max;
  logic stop_rev_ok;
  logic [SHT_W-1:0] raise_cnt;
  logic [SHT_W-1:0] stop_cnt;
  logic next_axle_down;
  logic next_auto_on;
  logic next_raise_valve;
  logic next_level_abort;
  logic next_axle_reverse;
  logic [SHT_W-1:0] next_raise_cnt;
  logic [SHT_W-1:0] next_stop_cnt;

  assign two_pos = opt[OPT_COMBO] | ~opt[OPT_BTN3]; // R8
  assign over_lim = bellows_press_i > press_limit_i;
  assign at_max = bellows_press_i >= press_max_i;
  // A reversal into a raise is barred where the load would force it down
  assign stop_rev_ok = opt[OPT_STOP_REV] && stop_cnt != '0 &&
                       speed_i == '0 && !axle_overload_i &&
                       !(axle_down_o && (opt[OPT_AUTO] ? at_max : over_lim));

  always_comb begin
    raise_cmd = rcu_raise_i | (two_pos ? fall_v[DB_AX_SW] // R6
                                       : rise_v[DB_AX_UP]); // R7
    lower_cmd = rcu_lower_i | (two_pos ? rise_v[DB_AX_SW] // R6
                                       : rise_v[DB_AX_DN]); // R7
    next_axle_down = axle_down_o;
    next_auto_on = auto_on_o;
    next_level_abort = 1'b0;
    next_axle_reverse = 1'b0;
    next_raise_cnt = raise_cnt;
    next_stop_cnt = stop_cnt;
    if (tick && raise_cnt != '0) begin
      next_raise_cnt = raise_cnt - 1'b1;
    end
    if (tick && stop_cnt != '0) begin
      next_stop_cnt = stop_cnt - 1'b1;
    end
    if (!opt[OPT_AUTO]) begin
      if (over_lim) begin
        next_axle_down = 1'b1; // R14
      end else if (speed_i <= spd_limit_i) begin
        if (lower_cmd) begin
          next_axle_down = 1'b1; // R13
        end else if (raise_cmd) begin
          next_axle_down = 1'b0; // R13
        end
      end
    end else if (at_max) begin
      next_axle_down = 1'b1; // R15
    end else begin
      if (auto_on_o && bellows_press_i < press_min_i) begin
        next_axle_down = 1'b0; // R15
      end
      if (lower_cmd) begin
        next_auto_on = 1'b0; // R17
        next_axle_down = 1'b1;
      end else if (raise_cmd) begin
        next_auto_on = 1'b1; // R17
      end
    end
    if (next_axle_down != axle_down_o) begin
      next_stop_cnt = STOP_TK;
    end
    // STOP always ends level control; the axle only turns on request
    if (rcu_stop_i) begin
      next_level_abort = 1'b1; // R18
      if (stop_rev_ok) begin
        next_axle_down = ~axle_down_o; // R19
        next_axle_reverse = 1'b1;
        next_stop_cnt = '0;
      end
    end
    if (next_axle_down) begin
      next_raise_cnt = '0;
    end else if (axle_down_o) begin
      next_raise_cnt = RAISE_TK; // R5
    end
    next_raise_valve = opt[OPT_RAISE_PERM] ? ~next_axle_down // R5
                                           : next_raise_cnt != '0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      axle_down_o <= 1'b1;
      auto_on_o <= 1'b1;
      raise_valve_o <= 1'b0;
      level_abort_o <= 1'b0;
      axle_reverse_o <= 1'b0;
      raise_cnt <= '0;
      stop_cnt <= '0;
    end else begin
      axle_down_o <= next_axle_down;
      auto_on_o <= next_auto_on;
      raise_valve_o <= next_raise_valve;
      level_abort_o <= next_level_abort;
      axle_reverse_o <= next_axle_reverse;
      raise_cnt <= next_raise_cnt;
      stop_cnt <= next_stop_cnt;
    end
  end

  // ==========================================================
  // Traction help
  latc_th_t th_st;
  latc_th_t next_th_st;
  logic [TH_W-1:0] th_cnt;
  logic [TH_W-1:0] next_th_cnt;
  logic [TH_W-1:0] limit_tk;
  logic th_cmd;
  logic th_level;
  logic th_allow;
  logic th_bounds;
  logic th_timed;
  logic th_end;

  always_comb begin
    limit_tk = TH_W'(th_time_s_i) * TH_W'(TICKS_PER_S);
    th_cmd = opt[OPT_COMBO] ? rise_v[DB_AX_UP] : rise_v[DB_TH_BTN]; // R8
    th_level = db[DB_TH_BTN];
    th_allow = opt[OPT_AUTO] && // R16
               (!(opt[OPT_RATIO] && opt[OPT_LA_UNSENSED]) ||
                db[DB_TH_EN]); // R3
    th_bounds = !over_lim && speed_i <= spd_limit_i; // R2
    th_timed = !opt[OPT_UNREG] || th_time_en_i; // R2
    th_end = th_cmd || !th_bounds || !th_allow ||
             (th_timed && th_cnt >= limit_tk); // R1
    next_th_st = th_st;
    next_th_cnt = th_cnt;
    if (tick) begin
      next_th_cnt = th_cnt + 1'b1;
    end
    case (th_st)
      TH_IDLE: begin
        next_th_cnt = '0;
        if (opt[OPT_NORTH]) begin
          if (th_level && th_allow) begin
            next_th_st = TH_ACTIVE; // R4
          end
        end else if (th_cmd && th_allow && th_bounds) begin
          next_th_st = TH_ACTIVE;
        end
      end
      TH_ACTIVE: begin
        if (opt[OPT_NORTH]) begin
          if (!th_level || !th_allow) begin
            next_th_st = TH_IDLE; // R4
          end
        end else if (th_end) begin
          next_th_cnt = '0;
          next_th_st = opt[OPT_UNREG] ? TH_IDLE : TH_PAUSE; // R1
        end
      end
      TH_PAUSE: begin
        // One extra tick covers the partial first tick period
        if (th_cnt > PAUSE_TK) begin
          next_th_st = TH_IDLE; // R1
        end
      end
      default: begin
        next_th_st = TH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      th_st <= TH_IDLE;
      th_cnt <= '0;
      th_active_o <= 1'b0;
      th_blocked_o <= 1'b0;
    end else begin
      th_st <= next_th_st;
      th_cnt <= next_th_cnt;
      th_active_o <= next_th_st == TH_ACTIVE;
      th_blocked_o <= next_th_st == TH_PAUSE;
    end
  end

  // ==========================================================
  // Normal level, fault lamp, pressure diagnostics
  logic fault_prev;
  logic [SHT_W-1:0] lamp_cnt;
  logic [SHT_W-1:0] next_lamp_cnt;
  logic next_level2;
  logic next_lamp;
  logic [DW-1:0] next_press_diag;

  always_comb begin
    next_level2 = level2_o;
    if (opt[OPT_NL_SPEED]) begin // R9
      if (speed_i > spd_up_i) begin
        next_level2 = 1'b1; // R10
      end else if (speed_i < spd_dn_i) begin
        next_level2 = 1'b0; // R10
      end
    end else if (!opt[OPT_NL_STEP]) begin
      next_level2 = db[DB_NL_SW]; // R11
    end else if (rise_v[DB_NL_UP]) begin
      next_level2 = 1'b1; // R11
    end else if (rise_v[DB_NL_DN]) begin
      next_level2 = 1'b0; // R11
    end
    next_lamp_cnt = lamp_cnt;
    if (minor_fault_i && !fault_prev) begin
      next_lamp_cnt = LAMP_TK; // R12
    end else if (tick && lamp_cnt != '0) begin
      next_lamp_cnt = lamp_cnt - 1'b1;
    end
    next_lamp = opt[OPT_LAMP_BRIEF] ? next_lamp_cnt != '0 // R12
                                    : minor_fault_i;
    next_press_diag = DW'(press_raw_i) *
                      DW'(opt[OPT_PRESS16] ? SCALE_16 // R21
                                           : SCALE_20); // R20
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fault_prev <= 1'b0;
      lamp_cnt <= '0;
      level2_o <= 1'b0;
      lamp_o <= 1'b0;
      press_diag_o <= '0;
    end else begin
      fault_prev <= minor_fault_i;
      lamp_cnt <= next_lamp_cnt;
      level2_o <= next_level2;
      lamp_o <= next_lamp;
      press_diag_o <= next_press_diag;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_th_end;
    $fell(th_active_o) && !opt[OPT_UNREG] && !opt[OPT_NORTH];
  endsequence
  sequence s_blocked_run;
    th_blocked_o [*8];
  endsequence

  AST_PAUSE_AFTER_END: assert property ( // R1
    s_th_end |-> s_blocked_run)
    else $error("Regulated help ended without a held pause");
  AST_TH_AUTO_ONLY: assert property ( // R16
    th_active_o |-> opt[OPT_AUTO])
    else $error("Traction help active without automatic mode");
  AST_TH_ENABLE: assert property ( // R3
    $rose(th_active_o) && opt[OPT_RATIO] && opt[OPT_LA_UNSENSED]
    |-> $past(db[DB_TH_EN]))
    else $error("Traction help started without enable switch");
  AST_RAISE_PERM: assert property ( // R5
    opt[OPT_RAISE_PERM] |-> raise_valve_o == !axle_down_o)
    else $error("Steady raise output does not follow axle");
  AST_RAISE_PULSE: assert property ( // R5
    !opt[OPT_RAISE_PERM] && $rose(raise_valve_o)
    |-> !axle_down_o ##1 raise_valve_o || axle_down_o)
    else $error("Raise pulse not tied to axle raising");
  AST_MAN_OVER: assert property ( // R14
    !opt[OPT_AUTO] && over_lim |=> axle_down_o && !th_active_o)
    else $error("Manual mode overpressure did not lower axle");
  AST_AUTO_MAX: assert property ( // R15
    opt[OPT_AUTO] && at_max |=> axle_down_o)
    else $error("Automatic mode ignored maximum pressure");
  AST_LEVEL_SPEED: assert property ( // R10
    opt[OPT_NL_SPEED] && speed_i > spd_up_i |=> level2_o)
    else $error("Upper speed did not select level two");
  AST_STOP_ABORT: assert property ( // R18
    rcu_stop_i |=> level_abort_o)
    else $error("STOP did not abort level control");
  AST_STOP_NO_REV: assert property ( // R18
    !opt[OPT_STOP_REV] |-> !axle_reverse_o)
    else $error("Axle reversed with reversal option clear");
  AST_LAMP_STEADY: assert property ( // R12
    !opt[OPT_LAMP_BRIEF] |=> lamp_o == $past(minor_fault_i))
    else $error("Steady lamp does not follow minor fault");
  AST_PRESS_SCALE: assert property ( // R20
    !opt[OPT_PRESS16]
    |=> press_diag_o == DW'($past(press_raw_i)) * DW'(SCALE_20))
    else $error("Pressure scaling wrong for 0.05 bar counts");
endmodule

// ### hdl/latc_pkg.sv
// Constants, option bit positions and types for axle and traction control
// Functional notes
// (R1) Regulated traction help ends by activation time, then blocks 50 s.
// (R2) Unregulated traction help: time limit optional, bounded by load and speed.
// (R3) Ratio variant, unsensed lift axle: activation needs enable switch asserted.
// (R4) Northern type: no limits, traction help follows the driver switch.
// (R5) Raise output: 5 s pulse when bit clear, steady when set.
// (R6) Two-position switch: act only on switch changes, not load or ignition.
// (R7) Three-position button: each momentary push is one command; neutral idle.
// (R8) Combination switch: axle switch plus spring-returned traction help push.
// (R9) Second normal level from switch when clear, from speed when set.
// (R10) Speed mode: level two above upper speed, back below lower speed.
// (R11) Switch mode: latching switch direct, or momentary switch stepping level.
// (R12) Minor fault lamp: steady when clear, few seconds then off when set.
// (R13) Manual mode: driver commands only below pressure limit and speed limit.
// (R14) Manual mode: over limit pressure lowers axle; traction help refused.
// (R15) Automatic mode: lower at maximum pressure, raise below minimum pressure.
// (R16) Traction help only when fully automatic axle control is configured.
// (R17) Below maximum: lower command disables automatic, raise re-enables it.
// (R18) Reversal clear: STOP aborts level control, axle movement continues.
// (R19) Reversal set: STOP within 5 s reverses axle, at standstill, no overload.
// (R20) Scaling clear: diagnostic pressure at 0.05 bar per count.
// (R21) Scaling set: diagnostic pressure at 0.0625 bar per count.
// (R22) Option bits are sampled at reset and held during operation.
// (R23) Switch inputs synchronised and debounced before edge detection.
package latc_pkg;
  // ==========================================================
  // Clock and time base
  localparam int CLK_MHZ = 50;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int DEB_MS = 20;
  localparam int DEB_CYC = DEB_MS * 1000 * CLK_MHZ;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  // ==========================================================
  // Timers, counted in ticks
  localparam int TH_W = 17;
  localparam int SHT_W = 6;
  localparam int PAUSE_S = 50;
  localparam int RAISE_S = 5;
  localparam int STOP_WIN_S = 5;
  localparam int LAMP_S = 3;
  localparam logic [TH_W-1:0] PAUSE_TK = TH_W'(PAUSE_S * TICKS_PER_S);
  localparam logic [SHT_W-1:0] RAISE_TK = SHT_W'(RAISE_S * TICKS_PER_S);
  localparam logic [SHT_W-1:0] STOP_TK = SHT_W'(STOP_WIN_S * TICKS_PER_S);
  localparam logic [SHT_W-1:0] LAMP_TK = SHT_W'(LAMP_S * TICKS_PER_S);
  // ==========================================================
  // Option bit positions and reset value
  localparam int OPT_UNREG = 0;
  localparam int OPT_NORTH = 1;
  localparam int OPT_RAISE_PERM = 2;
  localparam int OPT_BTN3 = 3;
  localparam int OPT_COMBO = 4;
  localparam int OPT_NL_SPEED = 5;
  localparam int OPT_NL_STEP = 6;
  localparam int OPT_LAMP_BRIEF = 7;
  localparam int OPT_AUTO = 8;
  localparam int OPT_STOP_REV = 9;
  localparam int OPT_PRESS16 = 10;
  localparam int OPT_RATIO = 11;
  localparam int OPT_LA_UNSENSED = 12;
  localparam int OPT_W = 13;
  localparam logic [OPT_W-1:0] OPT_RST = 13'h0000;
  // ==========================================================
  // Debounced input positions
  localparam int DB_AX_SW = 0;
  localparam int DB_AX_UP = 1;
  localparam int DB_AX_DN = 2;
  localparam int DB_TH_BTN = 3;
  localparam int DB_TH_EN = 4;
  localparam int DB_NL_SW = 5;
  localparam int DB_NL_UP = 6;
  localparam int DB_NL_DN = 7;
  localparam int DB_W = 8;
  // ==========================================================
  // Data widths and pressure scaling, in 0.0001 bar units
  localparam int PW = 10;
  localparam int SPW = 8;
  localparam int DW = 20;
  localparam logic [PW-1:0] SCALE_20 = 10'h1f4;
  localparam logic [PW-1:0] SCALE_16 = 10'h271;
  typedef enum logic [1:0] {
    TH_IDLE = 2'b00,
    TH_ACTIVE = 2'b01,
    TH_PAUSE = 2'b10
  } latc_th_t;
endpackage

// ### hdl/latc_tick.sv
// Divider giving a one-cycle tick enable
`timescale 1ns/10ps
module latc_tick import latc_pkg::*; #(
  parameter int DIV = TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Tick
  output logic tick_o
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;
  always_comb begin
    next_tick = 1'b0;
    next_cnt = cnt + 1'b1;
    if (cnt == LAST) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

// ### hdl/latc_debounce.sv
// Two-stage synchroniser and debouncer for a vector of switch pins
`timescale 1ns/10ps
module latc_debounce #(
  parameter int W = 8,
  parameter int CNT = 1000
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Pins and clean values
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] db_o,
  output logic valid_o
);
  localparam int CW = $clog2(CNT);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] cand;
  logic [CW-1:0] cnt;
  logic [W-1:0] next_cand;
  logic [W-1:0] next_db;
  logic [CW-1:0] next_cnt;
  logic next_valid;
  // Whole vector must hold still; one counter is cheaper than W of them
  always_comb begin
    next_cand = cand;
    next_db = db_o;
    next_cnt = cnt;
    next_valid = valid_o;
    if (s2 != cand) begin
      next_cand = s2;
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_db = cand; // R23
      next_valid = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s1 <= '0;
      s2 <= '0;
      cand <= '0;
      cnt <= '0;
      db_o <= '0;
      valid_o <= 1'b0;
    end else begin
      s1 <= raw_i;
      s2 <= s1;
      cand <= next_cand;
      cnt <= next_cnt;
      db_o <= next_db;
      valid_o <= next_valid;
    end
  end
endmodule

// ### verif/latc_switch_model.sv
// Driver switch panel model with contact bounce on every change
`timescale 1ns/10ps
module latc_switch_model (
  // Clock
  input wire logic sys_clk_i,
  // Wanted positions and pin levels
  input wire logic [7:0] want_i,
  output logic [7:0] pins_o
);
  logic [7:0] old = 8'h00;
  logic [7:0] last = 8'h00;
  logic [2:0] b = 3'h0;
  // ====================
  // Chatter
  // Contacts chatter one cycle at a time, so only debouncing hides it
  always @(negedge sys_clk_i) begin
    if (want_i != last) begin
      old <= pins_o;
      last <= want_i;
      b <= 3'h4;
      pins_o <= want_i;
    end else begin
      if (b != 3'h0) b <= b - 3'h1;
      pins_o <= b[0] ? old : last;
    end
  end
endmodule

// ### verif/latc_top_tb.sv
// Self-checking bench for axle, traction help, level and lamp control
`timescale 1ns/10ps
module latc_top_tb import latc_pkg::*; ;
  // ====================
  // Signals and table
  typedef struct packed {
    logic [OPT_W-1:0] opt;
    logic [PW-1:0] raw;
    logic flt;
    logic [DW-1:0] diag;
    logic lamp;
  } latc_row_t;
  latc_row_t rows [5] = '{
    '{13'h0000, 10'h014, 1'b1, 20'h02710, 1'b1},
    '{13'h0400, 10'h010, 1'b0, 20'h02710, 1'b0},
    '{13'h0400, 10'h3ff, 1'b1, 20'h9c18f, 1'b1},
    '{13'h0000, 10'h3ff, 1'b0, 20'h7ce0c, 1'b0},
    '{13'h0080, 10'h000, 1'b1, 20'h00000, 1'b1}};
  logic sys_clk_i = 1'b0, srst_i = 1'b1;
  logic [OPT_W-1:0] opt_i = 13'h0000;
  logic [7:0] want = 8'h00;
  logic [7:0] pins;
  logic rcu_raise_i = 1'b0, rcu_lower_i = 1'b0, rcu_stop_i = 1'b0;
  logic minor_fault_i = 1'b0, axle_overload_i = 1'b0;
  logic [SPW-1:0] speed_i = 8'h00, spd_limit_i = 8'h1e;
  logic [PW-1:0] bellows_press_i = 10'h096, press_raw_i = 10'h000;
  logic [PW-1:0] press_limit_i = 10'h0c8;
  logic [12:0] th_time_s_i = 13'h0064;
  // Timer enable is only read by the unregulated type
  logic th_time_en_i = 1'b0;
  logic [PW-1:0] press_max_i = 10'h12c, press_min_i = 10'h064;
  logic [SPW-1:0] spd_up_i = 8'h64, spd_dn_i = 8'h32;
  logic th_active_o, th_blocked_o, axle_down_o, auto_on_o, raise_valve_o;
  logic level2_o, lamp_o, level_abort_o, axle_reverse_o;
  logic [DW-1:0] press_diag_o;
  int err_count = 0;
  int checks_done = 0;

  latc_switch_model latc_switch_model_i (
    .sys_clk_i, .want_i(want), .pins_o(pins));
  latc_top #(.TICK_CYCLES(4), .DEB_CYCLES(4)) latc_top_i (
    .sys_clk_i, .srst_i, .opt_i,
    .axle_sw_i(pins[DB_AX_SW]), .axle_up_btn_i(pins[DB_AX_UP]),
    .axle_dn_btn_i(pins[DB_AX_DN]), .th_btn_i(pins[DB_TH_BTN]),
    .th_enable_sw_i(pins[DB_TH_EN]), .nl_sw_i(pins[DB_NL_SW]),
    .nl_up_btn_i(pins[DB_NL_UP]), .nl_dn_btn_i(pins[DB_NL_DN]),
    .rcu_raise_i, .rcu_lower_i, .rcu_stop_i, .minor_fault_i,
    .axle_overload_i, .speed_i, .bellows_press_i, .press_raw_i,
    .press_limit_i, .press_max_i, .press_min_i, .spd_limit_i, .spd_up_i,
    .spd_dn_i, .th_time_s_i, .th_time_en_i, .th_active_o, .th_blocked_o,
    .axle_down_o, .auto_on_o, .raise_valve_o, .level2_o, .lamp_o,
    .level_abort_o, .axle_reverse_o, .press_diag_o);

  initial forever #10 sys_clk_i = ~sys_clk_i;
  // ====================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Options are only taken while reset is high
  task automatic rst(input logic [OPT_W-1:0] o);
    srst_i = 1'b1;
    opt_i = o;
    want = 8'h00;
    minor_fault_i = 1'b0;
    axle_overload_i = 1'b0;
    speed_i = 8'h00;
    spd_limit_i = 8'h1e;
    bellows_press_i = 10'h096;
    press_limit_i = 10'h0c8;
    th_time_s_i = 13'h0064;
    th_time_en_i = 1'b0;
    cyc(5);
    srst_i = 1'b0;
    cyc(12);
  endtask
  task automatic cmd(input logic up);
    rcu_raise_i = up;
    rcu_lower_i = !up;
    cyc(1);
    {rcu_raise_i, rcu_lower_i} = 2'b00;
    cyc(2);
  endtask
  task automatic push(input int b);
    want[b] = 1'b1;
    cyc(15);
    want[b] = 1'b0;
    cyc(15);
  endtask
  // Counting pulses tolerates either answer cycle but not a long pulse
  task automatic stop_chk(input logic [DW-1:0] ea, input logic [DW-1:0] er);
    logic [DW-1:0] na;
    logic [DW-1:0] nr;
    na = '0;
    nr = '0;
    rcu_stop_i = 1'b1;
    cyc(1);
    rcu_stop_i = 1'b0;
    repeat (4) begin
      na = na + DW'(level_abort_o);
      nr = nr + DW'(axle_reverse_o);
      cyc(1);
    end
    chk(na, ea);
    chk(nr, er);
  endtask
  // ====================
  // Tests
  initial begin
    cyc(20000);
    err_count++;
    give_verdict();
  end
  initial begin
    cyc(5);
    chk(axle_down_o, 1'b1);
    chk(auto_on_o, 1'b1);
    chk({th_active_o, th_blocked_o, raise_valve_o, level2_o, lamp_o,
      level_abort_o, axle_reverse_o}, 7'h00);
    foreach (rows[i]) begin
      press_raw_i = rows[i].raw;
      rst(rows[i].opt);
      minor_fault_i = rows[i].flt;
      cyc(4);
      chk(press_diag_o, rows[i].diag);
      chk(lamp_o, rows[i].lamp);
    end
    rst(13'h0000);
    cmd(1'b1);
    chk(axle_down_o, 1'b0);
    chk(raise_valve_o, 1'b1);
    cyc(205);
    chk(raise_valve_o, 1'b0);
    spd_limit_i = 8'h00;
    speed_i = 8'h01;
    cmd(1'b0);
    chk(axle_down_o, 1'b0);
    speed_i = 8'h00;
    push(DB_TH_BTN);
    chk(th_active_o, 1'b0);
    want[DB_AX_SW] = 1'b1;
    cyc(20);
    chk(axle_down_o, 1'b1);
    want[DB_AX_SW] = 1'b0;
    cyc(20);
    chk(axle_down_o, 1'b0);
    press_limit_i = 10'h064;
    cyc(3);
    chk(axle_down_o, 1'b1);
    stop_chk(1, 0);
    rst(13'h0008);
    push(DB_AX_UP);
    chk(axle_down_o, 1'b0);
    cyc(20);
    chk(axle_down_o, 1'b0);
    push(DB_AX_DN);
    chk(axle_down_o, 1'b1);
    rst(13'h0004);
    cmd(1'b1);
    cyc(250);
    chk(raise_valve_o, 1'b1);
    rst(13'h0300);
    cmd(1'b0);
    chk(auto_on_o, 1'b0);
    chk(axle_down_o, 1'b1);
    cmd(1'b1);
    chk(auto_on_o, 1'b1);
    bellows_press_i = 10'h032;
    cyc(3);
    chk(axle_down_o, 1'b0);
    bellows_press_i = 10'h12c;
    cyc(3);
    chk(axle_down_o, 1'b1);
    bellows_press_i = 10'h096;
    cmd(1'b1);
    stop_chk(1, 1);
    chk(axle_down_o, 1'b0);
    bellows_press_i = 10'h12c;
    cyc(3);
    bellows_press_i = 10'h096;
    speed_i = 8'h01;
    stop_chk(1, 0);
    speed_i = 8'h00;
    axle_overload_i = 1'b1;
    stop_chk(1, 0);
    chk(axle_down_o, 1'b1);
    rst(13'h0100);
    th_time_s_i = 13'h0001;
    push(DB_TH_BTN);
    chk(th_active_o, 1'b1);
    cyc(40);
    chk(th_active_o, 1'b0);
    chk(th_blocked_o, 1'b1);
    push(DB_TH_BTN);
    chk(th_active_o, 1'b0);
    cyc(1900);
    chk(th_blocked_o, 1'b1);
    rst(13'h1900);
    push(DB_TH_BTN);
    chk(th_active_o, 1'b0);
    want[DB_TH_EN] = 1'b1;
    push(DB_TH_BTN);
    chk(th_active_o, 1'b1);
    rst(13'h0102);
    want[DB_TH_BTN] = 1'b1;
    cyc(20);
    chk(th_active_o, 1'b1);
    want[DB_TH_BTN] = 1'b0;
    cyc(20);
    chk(th_active_o, 1'b0);
    rst(13'h0110);
    push(DB_AX_UP);
    chk(th_active_o, 1'b1);
    rst(13'h0101);
    th_time_s_i = 13'h0001;
    push(DB_TH_BTN);
    cyc(40);
    chk(th_active_o, 1'b1);
    speed_i = 8'h1f;
    cyc(3);
    chk({th_active_o, th_blocked_o}, 2'b00);
    speed_i = 8'h00;
    th_time_en_i = 1'b1;
    push(DB_TH_BTN);
    chk(th_active_o, 1'b1);
    cyc(40);
    chk({th_active_o, th_blocked_o}, 2'b00);
    rst(13'h0020);
    speed_i = 8'h65;
    cyc(3);
    chk(level2_o, 1'b1);
    speed_i = 8'h3c;
    cyc(3);
    chk(level2_o, 1'b1);
    speed_i = 8'h31;
    cyc(3);
    chk(level2_o, 1'b0);
    rst(13'h0000);
    want[DB_NL_SW] = 1'b1;
    cyc(20);
    chk(level2_o, 1'b1);
    rst(13'h0040);
    push(DB_NL_UP);
    chk(level2_o, 1'b1);
    push(DB_NL_DN);
    chk(level2_o, 1'b0);
    rst(13'h0080);
    minor_fault_i = 1'b1;
    cyc(3);
    chk(lamp_o, 1'b1);
    cyc(130);
    chk(lamp_o, 1'b0);
    give_verdict();
  end
endmodule
